// ---- logic/glc_top.sv ----
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module glc_top #(
  parameter int unsigned MS_CYCLES = glc_pkg::MS_CYCLES
) (
  // clock and reset (reset stands for power-up)
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // apb register port
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [glc_pkg::AW-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // safety controller pins
  input  wire logic                  solenoid_req_ch1,
  input  wire logic                  solenoid_req_ch2,
  input  wire logic                  safety_in_ch1,
  input  wire logic                  safety_in_ch2,
  output logic                       safe_out_ch1,
  output logic                       safe_out_ch2,
  // diagnostics link pins
  input  wire logic                  diag_in,
  output logic                       diag_out,
  // mechanism sensing and solenoid drive
  input  wire logic                  actuator_present,
  input  wire logic                  lock_pin_locked,
  input  wire logic                  aux_release,
  input  wire logic                  escape_release,
  output logic                       lock_drive,
  output logic      [3:0]            error_code
);
  import glc_pkg::*;

  glc_sol_if sol ();

  //////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for every pin input
  localparam int unsigned NSYNC = 9;
  logic [NSYNC-1:0] pin_raw, sync1_reg, sync2_reg;

  assign pin_raw = {solenoid_req_ch1, solenoid_req_ch2, safety_in_ch1,
                    safety_in_ch2, diag_in, actuator_present,
                    lock_pin_locked, aux_release, escape_release};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  logic sol1_s, sol2_s, in1_s, in2_s, link_s, act_s, pin_s, aux_s, esc_s;
  assign {sol1_s, sol2_s, in1_s, in2_s, link_s, act_s, pin_s, aux_s,
          esc_s} = sync2_reg;

  //////////////////////////////////////////////////////////////////////
  // millisecond enable
  logic [DIV_W-1:0] div_reg, div_next;
  logic             tick;

  assign tick = (div_reg == DIV_W'(MS_CYCLES - 1));

  always_comb begin
    div_next = tick ? '0 : div_reg + 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register slave and solenoid edge classifier
  logic        dir_forced, cmd_pending, cmd_consume;
  logic [1:0]  mode_req;
  logic [31:0] status;

  glc_apb u_apb (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .dir_forced  (dir_forced),
    .mode_req    (mode_req),
    .cmd_pending (cmd_pending),
    .cmd_consume (cmd_consume),
    .status      (status)
  );

  assign sol.ms_tick    = tick;
  assign sol.dir_forced = dir_forced;
  assign sol.sol1       = sol1_s;
  assign sol.sol2       = sol2_s;

  glc_edge_det u_det (
    .sys_clk (sys_clk),
    .rst     (rst),
    .sol     (sol.det)
  );

  //////////////////////////////////////////////////////////////////////
  // operating mode
  glc_mode_e mode_reg, mode_next;

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      GLC_MODE_NONE: begin
        // wait for a live fieldbus module first
        if (link_s && mode_req == GLC_MODE_PASSIVE) begin
          mode_next = GLC_MODE_PASSIVE;
        end else if (link_s && mode_req == GLC_MODE_ACTIVE) begin
          mode_next = GLC_MODE_ACTIVE;
        end
      end
      GLC_MODE_PASSIVE, GLC_MODE_ACTIVE: begin
        if (!link_s || mode_req == GLC_MODE_NONE) begin
          mode_next = GLC_MODE_NONE;
        end else if (mode_req == GLC_MODE_PASSIVE ||
                     mode_req == GLC_MODE_ACTIVE) begin
          mode_next = glc_mode_e'(mode_req);
        end
      end
      default: mode_next = GLC_MODE_NONE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // request acceptance, processing delay, lock state, fault
  logic       any_req, accept, done;
  logic       busy_reg, busy_next, tgt_reg, tgt_next;
  logic       lock_reg, lock_next, fault_reg, fault_next;
  logic       esc_reg, esc_next;
  logic [9:0] proc_reg, proc_next;
  logic [3:0] err_reg, err_next;

  assign any_req = sol.req_lock | sol.req_unlock | sol.req_toggle;
  // link command alone never moves the lock
  assign accept  = any_req && !busy_reg && !fault_reg &&
                   (mode_reg != GLC_MODE_ACTIVE ||
                    (cmd_pending && sol1_s && sol2_s));
  assign cmd_consume = accept && mode_reg == GLC_MODE_ACTIVE;
  assign done    = busy_reg && tick && proc_reg == PROC_TIME_MS - 1'b1;

  always_comb begin
    busy_next  = busy_reg;
    tgt_next   = tgt_reg;
    proc_next  = proc_reg;
    lock_next  = lock_reg;
    fault_next = fault_reg;
    esc_next   = esc_reg | esc_s;
    err_next   = err_reg;
    if (accept) begin
      busy_next = 1'b1;
      proc_next = '0;
      tgt_next  = sol.req_toggle ? ~lock_reg : sol.req_lock;
    end else if (busy_reg && tick) begin
      proc_next = proc_reg + 1'b1;
    end
    if (done) begin
      busy_next = 1'b0;
      // activation refused while no actuator is engaged
      lock_next = tgt_reg & act_s;
    end
    // sticky until power-up; an unrestored release re-asserts it
    if (aux_s || esc_s) begin
      fault_next = 1'b1;
      lock_next  = 1'b0;
      busy_next  = 1'b0;
      if (err_reg == ERR_NONE) begin
        err_next = esc_s ? ERR_ESCAPE : ERR_AUX;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // safety outputs and diagnostics link
  logic       out_next, out_reg;
  logic [7:0] shift_reg, shift_next;
  logic [2:0] bit_reg, bit_next;
  logic       dout_reg, dout_next;
  logic [7:0] diag_word;

  always_comb begin
    out_next = act_s && pin_s && lock_reg && in1_s && in2_s;
    if (fault_reg || esc_reg) begin
      out_next = 1'b0;
    end
  end

  assign diag_word = {act_s, esc_reg, fault_reg, lock_reg, out_reg,
                      busy_reg, mode_reg};

  always_comb begin
    shift_next = shift_reg;
    bit_next   = bit_reg;
    dout_next  = dout_reg;
    if (mode_reg == GLC_MODE_NONE) begin
      // plain signal output: actuator status only
      dout_next = act_s;
      bit_next  = '0;
    end else if (tick) begin
      // serial status frame, one bit per millisecond
      if (bit_reg == 3'h0) begin
        shift_next = diag_word;
      end else begin
        shift_next = {shift_reg[6:0], 1'b0};
      end
      dout_next = (bit_reg == 3'h0) ? diag_word[7] : shift_reg[6];
      bit_next  = bit_reg + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_reg  <= GLC_MODE_NONE;
      busy_reg  <= 1'b0;
      tgt_reg   <= 1'b0;
      proc_reg  <= '0;
      lock_reg  <= 1'b0;
      fault_reg <= 1'b0;
      esc_reg   <= 1'b0;
      err_reg   <= ERR_NONE;
      out_reg   <= 1'b0;
      shift_reg <= '0;
      bit_reg   <= '0;
      dout_reg  <= 1'b0;
    end else begin
      mode_reg  <= mode_next;
      busy_reg  <= busy_next;
      tgt_reg   <= tgt_next;
      proc_reg  <= proc_next;
      lock_reg  <= lock_next;
      fault_reg <= fault_next;
      esc_reg   <= esc_next;
      err_reg   <= err_next;
      out_reg   <= out_next;
      shift_reg <= shift_next;
      bit_reg   <= bit_next;
      dout_reg  <= dout_next;
    end
  end

  assign safe_out_ch1 = out_reg;
  assign safe_out_ch2 = out_reg;
  assign lock_drive   = lock_reg;
  assign error_code   = err_reg;
  assign diag_out     = dout_reg;

  always_comb begin
    status = '0;
    status[ST_MODE_LSB +: 2] = mode_reg;
    status[ST_LOCK_BIT]      = lock_reg;
    status[ST_FAULT_BIT]     = fault_reg;
    status[ST_OUT1_BIT]      = out_reg;
    status[ST_OUT2_BIT]      = out_reg;
    status[ST_LINK_BIT]      = link_s;
    status[ST_ACT_BIT]       = act_s;
    status[ST_BUSY_BIT]      = busy_reg;
    status[ST_ERR_LSB +: 4]  = err_reg;
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  sequence s_release;
    aux_s || esc_s;
  endsequence
  sequence s_fault_seen;
    fault_reg && err_reg != ERR_NONE;
  endsequence

  a_reset_mode_none: assert property (@(posedge sys_clk)
    rst |=> mode_reg == GLC_MODE_NONE)
    else $error("mode not none after reset");

  a_none_no_frame: assert property (@(posedge sys_clk)
    disable iff (rst) mode_reg == GLC_MODE_NONE |=> dout_reg == $past(act_s))
    else $error("link driven in no-diagnostics mode");

  a_link_first: assert property (@(posedge sys_clk)
    disable iff (rst)
    $past(mode_reg) == GLC_MODE_NONE && mode_reg != GLC_MODE_NONE
    |-> $past(link_s))
    else $error("diagnostics mode without link");

  a_active_gate: assert property (@(posedge sys_clk)
    disable iff (rst)
    $rose(busy_reg) && $past(mode_reg) == GLC_MODE_ACTIVE
    |-> $past(cmd_pending && sol1_s && sol2_s))
    else $error("active change without command and solenoids");

  a_proc_bound: assert property (@(posedge sys_clk)
    disable iff (rst) busy_reg |-> proc_reg < PROC_TIME_MS)
    else $error("processing time exceeded");

  a_lock_via_proc: assert property (@(posedge sys_clk)
    disable iff (rst) $rose(lock_reg) |-> $past(done))
    else $error("lock changed without processed request");

  a_no_actuator: assert property (@(posedge sys_clk)
    disable iff (rst) $rose(lock_reg) |-> $past(act_s))
    else $error("lock set without actuator");

  a_release_fault: assert property (@(posedge sys_clk)
    disable iff (rst) s_release |=> s_fault_seen ##1 !out_reg)
    else $error("release did not raise fault");

  a_fault_sticky: assert property (@(posedge sys_clk)
    disable iff (rst) fault_reg |=> fault_reg [*8])
    else $error("fault cleared without power cycle");

  a_fault_out_low: assert property (@(posedge sys_clk)
    disable iff (rst) $past(fault_reg) |-> !safe_out_ch1 && !safe_out_ch2)
    else $error("outputs high in fault");

  a_outputs_cond: assert property (@(posedge sys_clk)
    disable iff (rst)
    out_reg |-> $past(act_s && pin_s && lock_reg && in1_s && in2_s))
    else $error("outputs high without conditions");

endmodule
`default_nettype wire

// ---- logic/glc_pkg.sv ----
`default_nettype none
package glc_pkg;

  ////////////////////////////////////////////////////////////////////
  // clock and time base
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TICK_TIME_NS  = 1000000;
  localparam int unsigned MS_CYCLES     = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned DIV_W         = 18;

  // all windows count whole millisecond ticks
  localparam int unsigned WIN_W          = 10;
  localparam logic [9:0]  PROC_TIME_MS   = 10'h064;
  localparam logic [9:0]  TOGGLE_WIN_MS  = 10'h014;
  localparam logic [9:0]  FORCE_MIN_MS   = 10'h028;
  localparam logic [9:0]  FORCE_MAX_MS   = 10'h1f4;

  ////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam int unsigned AW          = 8;
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_CMD    = 8'h04;
  localparam logic [7:0]  ADDR_STATUS = 8'h08;

  // ctrl fields
  localparam int unsigned CTRL_DIR_BIT  = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam logic [2:0]  CTRL_RESET    = 3'h0;
  // cmd fields
  localparam int unsigned CMD_ARM_BIT   = 0;
  // status fields
  localparam int unsigned ST_MODE_LSB   = 0;
  localparam int unsigned ST_LOCK_BIT   = 2;
  localparam int unsigned ST_FAULT_BIT  = 3;
  localparam int unsigned ST_OUT1_BIT   = 4;
  localparam int unsigned ST_OUT2_BIT   = 5;
  localparam int unsigned ST_LINK_BIT   = 6;
  localparam int unsigned ST_ACT_BIT    = 7;
  localparam int unsigned ST_BUSY_BIT   = 8;
  localparam int unsigned ST_ERR_LSB    = 12;

  ////////////////////////////////////////////////////////////////////
  // error codes
  localparam logic [3:0] ERR_NONE   = 4'h0;
  localparam logic [3:0] ERR_AUX    = 4'h1;
  localparam logic [3:0] ERR_ESCAPE = 4'h2;

  typedef enum logic [1:0] {
    GLC_MODE_NONE    = 2'b00,
    GLC_MODE_PASSIVE = 2'b01,
    GLC_MODE_ACTIVE  = 2'b10
  } glc_mode_e;

  typedef enum logic [1:0] {
    GLC_DET_IDLE  = 2'b00,
    GLC_DET_FIRST = 2'b01,
    GLC_DET_HOLD  = 2'b10
  } glc_det_e;

endpackage
`default_nettype wire

// ---- logic/glc_sol_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface glc_sol_if;
  logic ms_tick;
  logic dir_forced;
  logic sol1;
  logic sol2;
  logic req_lock;
  logic req_unlock;
  logic req_toggle;

  modport ctl (
    output ms_tick, dir_forced, sol1, sol2,
    input  req_lock, req_unlock, req_toggle
  );
  modport det (
    input  ms_tick, dir_forced, sol1, sol2,
    output req_lock, req_unlock, req_toggle
  );
endinterface
`default_nettype wire

// ---- logic/glc_edge_det.sv ----
`timescale 1ns/10ps
`default_nettype none
module glc_edge_det (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // solenoid channels and requests
  glc_sol_if.det    sol
);
  import glc_pkg::*;

  glc_det_e          state_reg, state_next;
  logic              first1_reg, first1_next;
  logic [WIN_W-1:0]  cnt_reg, cnt_next;
  logic              s1_d_reg, s2_d_reg;
  logic              lock_next, unlock_next, toggle_next;
  logic              lock_reg, unlock_reg, toggle_reg;
  logic              rise1, rise2;

  assign rise1 = sol.sol1 & ~s1_d_reg;
  assign rise2 = sol.sol2 & ~s2_d_reg;

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next  = state_reg;
    first1_next = first1_reg;
    cnt_next    = cnt_reg;
    lock_next   = 1'b0;
    unlock_next = 1'b0;
    toggle_next = 1'b0;
    case (state_reg)
      GLC_DET_IDLE: begin
        cnt_next = '0;
        // both low keeps everything still
        if (rise1 && rise2) begin
          toggle_next = ~sol.dir_forced;
          state_next  = GLC_DET_HOLD;
        end else if (rise1 || rise2) begin
          first1_next = rise1;
          state_next  = GLC_DET_FIRST;
        end
      end
      GLC_DET_FIRST: begin
        if (sol.ms_tick && cnt_reg != {WIN_W{1'b1}}) begin
          cnt_next = cnt_reg + 1'b1;
        end
        if ((first1_reg && rise2) || (!first1_reg && rise1)) begin
          state_next = GLC_DET_HOLD;
          if (!sol.dir_forced) begin
            toggle_next = (cnt_reg < TOGGLE_WIN_MS);
          end else if (cnt_reg >= FORCE_MIN_MS &&
                       cnt_reg <= FORCE_MAX_MS) begin
            lock_next   = first1_reg;
            unlock_next = ~first1_reg;
          end
        end else if (!sol.sol1 && !sol.sol2) begin
          state_next = GLC_DET_IDLE;
        end else if (cnt_reg > FORCE_MAX_MS) begin
          state_next = GLC_DET_HOLD;
        end
      end
      GLC_DET_HOLD: begin
        // a new request needs both channels low first
        if (!sol.sol1 && !sol.sol2) begin
          state_next = GLC_DET_IDLE;
        end
      end
      default: state_next = GLC_DET_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg  <= GLC_DET_IDLE;
      first1_reg <= 1'b0;
      cnt_reg    <= '0;
      s1_d_reg   <= 1'b0;
      s2_d_reg   <= 1'b0;
      lock_reg   <= 1'b0;
      unlock_reg <= 1'b0;
      toggle_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      first1_reg <= first1_next;
      cnt_reg    <= cnt_next;
      s1_d_reg   <= sol.sol1;
      s2_d_reg   <= sol.sol2;
      lock_reg   <= lock_next;
      unlock_reg <= unlock_next;
      toggle_reg <= toggle_next;
    end
  end

  assign sol.req_lock   = lock_reg;
  assign sol.req_unlock = unlock_reg;
  assign sol.req_toggle = toggle_reg;

endmodule
`default_nettype wire

// ---- logic/glc_apb.sv ----
`timescale 1ns/10ps
`default_nettype none
module glc_apb (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [glc_pkg::AW-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // block side
  output logic                       dir_forced,
  output logic      [1:0]            mode_req,
  output logic                       cmd_pending,
  input  wire logic                  cmd_consume,
  input  wire logic [31:0]           status
);
  import glc_pkg::*;

  function automatic logic [2:0] addr_dec(input logic [AW-1:0] a);
    addr_dec = 3'h0;
    if (a == ADDR_CTRL)   addr_dec = 3'h1;
    if (a == ADDR_CMD)    addr_dec = 3'h2;
    if (a == ADDR_STATUS) addr_dec = 3'h4;
  endfunction

  logic [2:0]  ctrl_reg, ctrl_next;
  logic        pend_reg, pend_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        wr_acc;
  logic [2:0]  hit;

  assign hit    = addr_dec(paddr);
  assign wr_acc = psel & penable & pwrite;

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    ctrl_next  = ctrl_reg;
    rdata_next = rdata_reg;
    if (wr_acc && hit[0]) begin
      ctrl_next = pwdata[2:0];
    end
    // set wins over consume in the same cycle
    pend_next = (pend_reg & ~cmd_consume) |
                (wr_acc & hit[1] & pwdata[CMD_ARM_BIT]);
    // read data captured in the setup cycle
    if (psel && !penable && !pwrite) begin
      rdata_next = '0;
      if (hit[0]) rdata_next = {29'h0, ctrl_reg};
      if (hit[1]) rdata_next = {31'h0, pend_reg};
      if (hit[2]) rdata_next = status;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_reg  <= CTRL_RESET;
      pend_reg  <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      ctrl_reg  <= ctrl_next;
      pend_reg  <= pend_next;
      rdata_reg <= rdata_next;
    end
  end

  assign prdata      = rdata_reg;
  assign pready      = 1'b1;
  assign pslverr     = psel & penable & (hit == 3'h0);
  assign dir_forced  = ctrl_reg[CTRL_DIR_BIT];
  assign mode_req    = ctrl_reg[CTRL_MODE_LSB +: 2];
  assign cmd_pending = pend_reg;

endmodule
`default_nettype wire

// ---- tb/glc_ctl_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module glc_ctl_model #(
  parameter int MS = 20
) (
  input  wire logic sys_clk,
  output logic      sol1,
  output logic      sol2
);
  initial begin
    sol1 = 1'b0;
    sol2 = 1'b0;
  end
  // gap 0 raises both at one edge; else the leader goes first
  task automatic pulse(input bit ch2_first, input int gap_ms);
    @(posedge sys_clk);
    sol1 <= !ch2_first || gap_ms == 0;
    sol2 <= ch2_first || gap_ms == 0;
    if (gap_ms > 0) begin
      repeat (gap_ms * MS) @(posedge sys_clk);
      sol1 <= 1'b1;
      sol2 <= 1'b1;
    end
    // both drop before any next request, or it is not taken
    repeat (10 * MS) @(posedge sys_clk);
    sol1 <= 1'b0;
    sol2 <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb/glc_top_test.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin \
  num_checks++; \
  if ((a) !== (e)) begin \
    fail_count++; \
    $display("MISMATCH %0t got %0h want %0h", $time, a, e); \
  end \
end
module glc_top_test;
  import glc_pkg::*;
  localparam int MS = 20;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        solenoid_req_ch1, solenoid_req_ch2, safety_in_ch1;
  logic        safety_in_ch2, safe_out_ch1, safe_out_ch2, diag_in;
  logic        diag_out, actuator_present, lock_pin_locked, aux_release;
  logic        escape_release, lock_drive;
  logic [3:0]  error_code;
  int          fail_count, num_checks;
  wire  [1:0]  so = {safe_out_ch1, safe_out_ch2};

  glc_top #(.MS_CYCLES(MS)) glc_top_inst (
    .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .solenoid_req_ch1, .solenoid_req_ch2,
    .safety_in_ch1, .safety_in_ch2, .safe_out_ch1, .safe_out_ch2,
    .diag_in, .diag_out, .actuator_present, .lock_pin_locked,
    .aux_release, .escape_release, .lock_drive, .error_code
  );
  glc_ctl_model #(.MS(MS)) glc_ctl_model_inst (
    .sys_clk, .sol1(solenoid_req_ch1), .sol2(solenoid_req_ch2)
  );

  always #2.5 sys_clk = ~sys_clk;
  // pin sensor trails the drive, as the mechanism would
  always @(posedge sys_clk) lock_pin_locked <= lock_drive;

  //////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic hard_reset();
    @(posedge sys_clk) rst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    cyc(2);
  endtask
  task automatic apb(input bit wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic mode_is(input logic [1:0] m);
    cyc(8);
    apb(1'b0, ADDR_STATUS, '0);
    `CHK(rd[1:0], m)
  endtask
  // fixed waits: processing is a fixed 100 ms after the second edge
  task automatic req(input bit c2, input int gap, input logic exp);
    logic old;
    old = lock_drive;
    glc_ctl_model_inst.pulse(c2, gap);
    cyc(1770);
    `CHK(lock_drive, old)
    cyc(100);
    `CHK(lock_drive, exp)
  endtask

  //////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK({lock_drive, so, error_code}, 7'h0)
    mode_is(GLC_MODE_NONE);
    apb(1'b0, ADDR_CTRL, '0);
    `CHK(rd[2:0], CTRL_RESET)
    apb(1'b0, 8'h0c, '0);
    `CHK({er, rd}, {1'b1, 32'h0})
    $display("test reset done");
  endtask
  task automatic t_toggle();
    req(1'b0, 0, 1'b0);
    @(posedge sys_clk) actuator_present <= 1'b1;
    safety_in_ch1 <= 1'b1;
    safety_in_ch2 <= 1'b1;
    cyc(8);
    `CHK(diag_out, 1'b1)
    req(1'b0, 0, 1'b1);
    cyc(8);
    `CHK(so, 2'b11)
    @(posedge sys_clk) safety_in_ch2 <= 1'b0;
    cyc(8);
    `CHK(so, 2'b00)
    @(posedge sys_clk) safety_in_ch2 <= 1'b1;
    cyc(300);
    `CHK(lock_drive, 1'b1)
    req(1'b0, 10, 1'b0);
    req(1'b0, 30, 1'b0);
    $display("test toggle done");
  endtask
  task automatic t_forced();
    apb(1'b1, ADDR_CTRL, 32'h1);
    req(1'b0, 100, 1'b1);
    req(1'b1, 100, 1'b0);
    req(1'b0, 20, 1'b0);
    req(1'b0, 0, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0);
    $display("test forced done");
  endtask
  task automatic t_diag();
    logic lo;
    lo = 1'b0;
    @(posedge sys_clk) diag_in <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h2);
    mode_is(GLC_MODE_PASSIVE);
    repeat (20 * MS) begin
      cyc(1);
      lo |= !diag_out;
    end
    `CHK(lo, 1'b1)
    req(1'b0, 0, 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h4);
    mode_is(GLC_MODE_ACTIVE);
    req(1'b0, 0, 1'b1);
    apb(1'b1, ADDR_CMD, 32'h1);
    apb(1'b0, ADDR_CMD, '0);
    `CHK(rd[CMD_ARM_BIT], 1'b1)
    cyc(2100);
    `CHK(lock_drive, 1'b1)
    req(1'b0, 0, 1'b0);
    apb(1'b0, ADDR_CMD, '0);
    `CHK(rd[CMD_ARM_BIT], 1'b0)
    @(posedge sys_clk) diag_in <= 1'b0;
    mode_is(GLC_MODE_NONE);
    apb(1'b1, ADDR_CTRL, 32'h0);
    $display("test diag done");
  endtask
  task automatic t_fault();
    req(1'b0, 0, 1'b1);
    @(posedge sys_clk) aux_release <= 1'b1;
    cyc(8);
    `CHK({so, error_code}, {2'b00, ERR_AUX})
    apb(1'b0, ADDR_STATUS, '0);
    `CHK({rd[ST_ERR_LSB +: 4], rd[ST_FAULT_BIT]}, {ERR_AUX, 1'b1})
    req(1'b0, 0, 1'b0);
    @(posedge sys_clk) aux_release <= 1'b0;
    cyc(8);
    `CHK({so, error_code}, {2'b00, ERR_AUX})
    hard_reset();
    `CHK(error_code, ERR_NONE)
    req(1'b0, 0, 1'b1);
    cyc(8);
    `CHK(so, 2'b11)
    @(posedge sys_clk) escape_release <= 1'b1;
    cyc(8);
    `CHK({so, error_code}, {2'b00, ERR_ESCAPE})
    $display("test fault done");
  endtask

  //////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {safety_in_ch1, safety_in_ch2, diag_in, actuator_present} = '0;
    {aux_release, escape_release} = '0;
    fail_count = 0;
    num_checks = 0;
    hard_reset();
    t_reset();
    t_toggle();
    t_forced();
    t_diag();
    t_fault();
    finish_test();
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
